// ---- iar_regs.sv ----
// instruction sequencing registers: backup, tag, address, counter, index
// assumes sequencer supplies one-cycle controls and index adder results
// Notes on behaviour
// [RQ1] backup register holds 36 bits, the next sequential instruction
// [RQ2] backup captures next instruction alongside current op load or data fetch
// [RQ3] index adder bits 3-17 load backup bits 21-35
// [RQ4] bus-loaded backup output follows bus at once; accumulator load is clocked
// [RQ5] on overlap start backup op field moves to operation register
// [RQ6] backup 18-20 feed tag register; 21-34 drive memory address switch
// [RQ7] backup 21-35 go to index adders for address modification
// [RQ8] backup 3-17 go to index adders for overlapped index instructions
// [RQ9] tag register loads from bus, backup, or storage word register
// [RQ10] seven-index mode decodes code; three-index mode ORs set bits
// [RQ11] power-on three-index; two commands switch mode
// [RQ12] address register 15 bits, loads only from index adders
// [RQ13] traps force address bits 3, 16, 17 on
// [RQ14] address bit 17 picks even/odd memory, or sets address bit 3 in diag
// [RQ15] address bit 3 or 17 updates odd flag, read back in status register; counter bit 17 picks the bus
// [RQ16] next counter formed at time 6, held, returned unchanged at time 1
// [RQ17] program counter loads only from adders; traps force bits 3, 16, 17
// [RQ18] overlapped store to next location cancels overlap
// [RQ19] counter bit 17 steers memory, or sets address bit 3 in diag
// [RQ20] odd counter gates even bus to storage/op, odd bus to backup
// [RQ21] seven identical 15-bit index registers
// [RQ22] short op field to positions s,8-9; long field to s,1-9
// [RQ23] index mode holds until opposite command or power-on
`timescale 1ns/1ps
module iar_regs
    import iar_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iar_bus_t bus_i,
    input wire iar_ctrl_t ctrl_i,
    input wire logic [14:0] index_adder_out_i,
    input wire logic [35:0] accumulator_reg_i,
    input wire logic [35:0] storage_word_reg_i,
    input wire logic [14:0] store_addr_i,
    input wire logic enter_seven_index_mode_i,
    input wire logic enter_three_index_mode_i,
    output logic [35:0] instruction_backup_o,
    output logic [35:0] storage_gate_o,
    output logic [9:0] operation_code_reg_o,
    output logic [2:0] index_tag_reg_o,
    output logic [6:0] index_select_o,
    output logic [14:0] adder_a_o,
    output logic [14:0] adder_b_o,
    output logic [14:0] adder_xr_o,
    output logic [14:0] memory_address_switch_o,
    output logic mem_odd_o,
    output logic overlap_cancel_o
);
    // machine positions: bit 35 of a word is position s, bit 0 position 35
    logic [35:0] ibr_r, ibr_nxt;
    logic [2:0] tag_r, tag_nxt;
    logic [14:0] ar_r, ar_nxt;
    logic [14:0] pc_r, pc_nxt;
    logic [14:0] xr_r [IAR_NUM_XR];
    logic [9:0] opc_r;
    logic seven_r, diag_r, odd_r, cancel_r, bus_fresh_r;
    logic [31:0] rdata_r;
    logic [35:0] ibr_bus_word, sr_bus_word;
    logic [6:0] sel_seven, sel_three, sel;
    logic [14:0] xr_or;
    logic [14:0] mas_addr, mas_nxt;
    logic mas_odd;
    logic store_hit;
    logic wr_acc, rd_acc, wr_ctrl;

    // odd counter: odd bus to backup, even bus to storage/op path
    assign ibr_bus_word = pc_r[0] ? bus_i.odd_word : bus_i.even_word; // RQ20
    assign sr_bus_word = pc_r[0] ? bus_i.even_word : bus_i.odd_word; // RQ20

    always_comb begin
        ibr_nxt = ibr_r;
        unique case (ctrl_i.ibr_src)
            IAR_IBR_HOLD: ibr_nxt = ibr_r;
            IAR_IBR_BUS: ibr_nxt = ibr_bus_word; // RQ2
            IAR_IBR_ACC: ibr_nxt = accumulator_reg_i;
            IAR_IBR_XAD: ibr_nxt = {ibr_r[35:15], index_adder_out_i}; // RQ3
        endcase
    end

    // bus path is transparent: outputs follow the bus within the cycle
    assign instruction_backup_o = (ctrl_i.ibr_src == IAR_IBR_BUS) ? ibr_bus_word : ibr_r; // RQ4
    assign storage_gate_o = sr_bus_word;

    always_comb begin
        tag_nxt = tag_r;
        if (ctrl_i.tag_from_bus) begin
            tag_nxt = sr_bus_word[17:15]; // RQ9
        end else if (ctrl_i.tag_from_ibr) begin
            tag_nxt = ibr_r[17:15]; // RQ6
        end else if (ctrl_i.tag_from_sr) begin
            tag_nxt = storage_word_reg_i[17:15];
        end
    end

    // tag bits: bit 2 = position 18 (value 4), bit 0 = position 20 (value 1)
    genvar g;
    generate
        for (g = 0; g < IAR_NUM_XR; g++) begin : g_xr
            assign sel_seven[g] = (tag_r == 3'(g + 1)); // RQ10
            // only registers 1, 2 and 4 answer to a single tag bit; index stays in range
            assign sel_three[g] = (g == 0) ? tag_r[0] : (g == 1) ? tag_r[1] : (g == 3) ? tag_r[2] : 1'b0; // RQ10
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    xr_r[g] <= IAR_ADDR_RST;
                end else if (ctrl_i.xr_load[g]) begin
                    xr_r[g] <= index_adder_out_i; // RQ21
                end
            end
        end
    endgenerate
    assign sel = seven_r ? sel_seven : sel_three;

    // multiple selections in three-index mode are OR'ed together
    always_comb begin
        xr_or = '0;
        for (int i = 0; i < IAR_NUM_XR; i++) begin
            if (sel[i]) begin
                xr_or = xr_or | xr_r[i]; // RQ10
            end
        end
    end

    always_comb begin
        ar_nxt = ar_r;
        if (ctrl_i.ar_load) begin
            ar_nxt = index_adder_out_i; // RQ12
        end
        if (ctrl_i.trap_force) begin
            ar_nxt = ar_nxt | IAR_TRAP_FORCE; // RQ13
        end
    end

    // counter value arrives back unchanged through the adders at time 1
    always_comb begin
        pc_nxt = pc_r;
        if (ctrl_i.pc_load) begin
            pc_nxt = index_adder_out_i; // RQ16 RQ17
        end
        if (ctrl_i.trap_force) begin
            pc_nxt = pc_nxt | IAR_TRAP_FORCE; // RQ17
        end
    end

    // diag: bit 17 joins the address as bit 3, memory pick forced even
    assign mas_addr = ctrl_i.use_pc_addr ? pc_r : (ctrl_i.ibr_src == IAR_IBR_HOLD ? ar_r : {1'b0, ibr_r[14:1]});
    assign mas_odd = diag_r ? 1'b0 : mas_addr[0]; // RQ14 RQ19
    assign mas_nxt = diag_r ? {mas_addr[14] | mas_addr[0], mas_addr[13:0]} : mas_addr; // RQ14 RQ19

    // complement counter plus store address all-ones means equal
    assign store_hit = ctrl_i.store_check && ((~pc_r + store_addr_i) == 15'h7fff); // RQ18

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && !penable;
    assign wr_ctrl = wr_acc && (paddr == IAR_OFS_CTRL);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ibr_r <= IAR_WORD_RST;
            tag_r <= '0;
            ar_r <= IAR_ADDR_RST;
            pc_r <= IAR_ADDR_RST;
        end else begin
            ibr_r <= ibr_nxt; // RQ1
            tag_r <= tag_nxt;
            ar_r <= ar_nxt;
            pc_r <= pc_nxt;
        end
    end

    // op field: short form to s,8-9; long form s,3-11 to s,1-9
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opc_r <= '0;
        end else if (ctrl_i.op_from_ibr) begin
            opc_r <= ctrl_i.op_short ? {ibr_r[35], 7'h00, ibr_r[34:33]}
                                     : {ibr_r[35], ibr_r[32:24]}; // RQ5 RQ22
        end
    end

    // a seven-index command, from software or instruction, wins over any three-index one
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seven_r <= IAR_MODE_RST; // RQ11
        end else if (enter_seven_index_mode_i || (wr_ctrl && pwdata[IAR_CTRL_SEVEN])) begin
            seven_r <= 1'b1; // RQ11 RQ23
        end else if (enter_three_index_mode_i || (wr_ctrl && pwdata[IAR_CTRL_THREE])) begin
            seven_r <= 1'b0; // RQ11 RQ23
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            diag_r <= 1'b0;
            odd_r <= 1'b0;
            cancel_r <= 1'b0;
            bus_fresh_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                diag_r <= pwdata[IAR_CTRL_DIAG];
            end
            if (ctrl_i.ar_load || ctrl_i.trap_force) begin
                odd_r <= diag_r ? ar_nxt[14] : ar_nxt[0]; // RQ15
            end
            cancel_r <= store_hit; // RQ18
            bus_fresh_r <= bus_i.even_valid | bus_i.odd_valid;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            operation_code_reg_o <= '0;
            index_tag_reg_o <= '0;
            index_select_o <= '0;
            adder_a_o <= '0;
            adder_b_o <= '0;
            adder_xr_o <= '0;
            memory_address_switch_o <= '0;
            mem_odd_o <= 1'b0;
            overlap_cancel_o <= 1'b0;
        end else begin
            operation_code_reg_o <= opc_r;
            index_tag_reg_o <= tag_r;
            index_select_o <= sel;
            adder_a_o <= ibr_r[14:0]; // RQ7
            adder_b_o <= ibr_r[32:18]; // RQ8
            adder_xr_o <= xr_or;
            memory_address_switch_o <= mas_nxt; // RQ6
            mem_odd_o <= mas_odd;
            overlap_cancel_o <= store_hit; // RQ18
        end
    end

    // apb: no wait states, read data latched in setup
    always_comb begin
        rdata_r = 32'h00000000;
        unique case (paddr)
            IAR_OFS_CTRL: rdata_r = {29'h0, seven_r, seven_r, diag_r};
            IAR_OFS_STAT: rdata_r = {28'h0, bus_fresh_r, cancel_r, odd_r, seven_r};
            IAR_OFS_PC: rdata_r = {17'h0, pc_r};
            IAR_OFS_AR: rdata_r = {17'h0, ar_r};
            IAR_OFS_IBRL: rdata_r = ibr_r[31:0];
            IAR_OFS_IBRH: rdata_r = {28'h0, ibr_r[35:32]};
            default: rdata_r = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_acc) begin
                prdata <= rdata_r;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > IAR_OFS_IBRH || paddr[1:0] != 2'b00);
        end
    end

    a_mode_reset: assert property (@(posedge clk_i) $rose(arst_n_i) |-> !seven_r) // RQ11
        else $error("mode not three-index after reset");
    a_mode_seven: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        enter_seven_index_mode_i |=> seven_r) // RQ11
        else $error("seven-index command ignored");
    a_mode_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !enter_seven_index_mode_i && !enter_three_index_mode_i && !wr_ctrl |=> $stable(seven_r)) // RQ23
        else $error("mode changed with no command");
    a_trap_force: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.trap_force |=> (ar_r[14] && ar_r[1] && ar_r[0] && pc_r[14] && pc_r[1] && pc_r[0])) // RQ13
        else $error("trap did not force bits");
    a_pc_only_adder: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_i.pc_load && !ctrl_i.trap_force |=> $stable(pc_r)) // RQ17
        else $error("counter changed without load");
    a_ar_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ar_load && !ctrl_i.trap_force |=> ar_r == $past(index_adder_out_i)) // RQ12
        else $error("address register load wrong");
    a_three_or: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !seven_r && tag_r == 3'h3 |-> sel == 7'h03) // RQ10
        else $error("three-index or selection wrong");
    a_seven_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        seven_r && tag_r != 3'h0 |-> $onehot(sel)) // RQ10
        else $error("seven-index selection not single");
    a_cancel_hit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.store_check && store_addr_i == pc_r |=> overlap_cancel_o) // RQ18
        else $error("overlap not cancelled");
    a_ibr_xad: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ibr_src == IAR_IBR_XAD |=> ibr_r[14:0] == $past(index_adder_out_i)) // RQ3
        else $error("adder not loaded into backup");
    a_ibr_xad_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ibr_src == IAR_IBR_XAD |=> ibr_r[35:15] == $past(ibr_r[35:15])) // RQ3
        else $error("adder load disturbed upper backup bits");
    a_ibr_bus_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ibr_src == IAR_IBR_BUS |-> instruction_backup_o == ibr_bus_word) // RQ4
        else $error("backup output not following bus");
    a_ibr_bus_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ibr_src == IAR_IBR_BUS |=> ibr_r == $past(ibr_bus_word)) // RQ2
        else $error("backup did not capture bus word");
    a_ibr_acc_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ibr_src == IAR_IBR_ACC |=> ibr_r == $past(accumulator_reg_i)) // RQ4
        else $error("backup did not capture accumulator");
    a_ibr_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ibr_src == IAR_IBR_HOLD |=> $stable(ibr_r)) // RQ1
        else $error("backup changed while holding");
    a_gate_odd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pc_r[0] |-> ibr_bus_word == bus_i.odd_word && storage_gate_o == bus_i.even_word) // RQ20
        else $error("odd counter bus gating wrong");
    a_gate_even: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !pc_r[0] |-> ibr_bus_word == bus_i.even_word && storage_gate_o == bus_i.odd_word) // RQ20
        else $error("even counter bus gating wrong");
    a_tag_bus: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.tag_from_bus |=> tag_r == $past(sr_bus_word[17:15])) // RQ9
        else $error("tag not loaded from bus");
    a_tag_ibr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.tag_from_ibr && !ctrl_i.tag_from_bus |=> tag_r == $past(ibr_r[17:15])) // RQ6
        else $error("tag not loaded from backup");
    a_tag_sr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.tag_from_sr && !ctrl_i.tag_from_bus && !ctrl_i.tag_from_ibr
        |=> tag_r == $past(storage_word_reg_i[17:15])) // RQ9
        else $error("tag not loaded from storage word");
    a_pc_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.pc_load && !ctrl_i.trap_force |=> pc_r == $past(index_adder_out_i)) // RQ16
        else $error("counter not returned unchanged");
    a_ar_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_i.ar_load && !ctrl_i.trap_force |=> $stable(ar_r)) // RQ12
        else $error("address register counted on its own");
    a_three_none: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !seven_r |-> !sel[2] && !sel[4] && !sel[5] && !sel[6]) // RQ10
        else $error("three-index mode selected a high register");
    a_seven_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        seven_r && tag_r == 3'h0 |-> sel == 7'h00) // RQ10
        else $error("zero tag selected a register");
    a_mode_three: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        enter_three_index_mode_i && !enter_seven_index_mode_i && !wr_ctrl |=> !seven_r) // RQ11
        else $error("three-index command ignored");
    a_mode_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_ctrl && pwdata[IAR_CTRL_SEVEN] |=> seven_r) // RQ11
        else $error("seven-index write ignored");
    a_cancel_miss: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_i.store_check |=> !overlap_cancel_o) // RQ18
        else $error("overlap cancelled with no store");
    a_mas_normal: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !diag_r |=> memory_address_switch_o == $past(mas_addr) && mem_odd_o == $past(mas_addr[0])) // RQ14
        else $error("normal mode address steering wrong");
    a_mas_diag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        diag_r && mas_addr[0] |=> !mem_odd_o && memory_address_switch_o[14]) // RQ14 RQ19
        else $error("diagnostic address bit not set");
    a_op_long: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.op_from_ibr && !ctrl_i.op_short |=> opc_r[8:0] == $past(ibr_r[32:24])) // RQ5 RQ22
        else $error("long operation field misplaced");
    a_op_short: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.op_from_ibr && ctrl_i.op_short |=> opc_r[1:0] == $past(ibr_r[34:33])) // RQ5 RQ22
        else $error("short operation field misplaced");
    a_xr_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.xr_load[0] |=> xr_r[0] == $past(index_adder_out_i)) // RQ21
        else $error("index register not loaded");
    a_odd_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_i.ar_load && !ctrl_i.trap_force && !diag_r |=> odd_r == $past(index_adder_out_i[0])) // RQ15
        else $error("odd flag not following address");
    a_pready_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        psel && !penable |=> pready)
        else $error("no ready after setup");
    a_pready_drop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
endmodule

// ---- iar_pkg.sv ----
// package for the instruction address register group
// assumes a single cpu clock; bit numbering follows machine positions
package iar_pkg;
    localparam int IAR_WORD_W = 36;
    localparam int IAR_ADDR_W = 15;
    localparam int IAR_TAG_W = 3;
    localparam int IAR_NUM_XR = 7;
    localparam int IAR_OPC_W = 10;
    localparam logic [14:0] IAR_TRAP_FORCE = 15'h4003;
    localparam logic [14:0] IAR_ADDR_RST = 15'h0000;
    localparam logic [35:0] IAR_WORD_RST = 36'h000000000;
    localparam logic IAR_MODE_RST = 1'b0;
    localparam logic [31:0] IAR_OFS_CTRL = 32'h00000000;
    localparam logic [31:0] IAR_OFS_STAT = 32'h00000004;
    localparam logic [31:0] IAR_OFS_PC = 32'h00000008;
    localparam logic [31:0] IAR_OFS_AR = 32'h0000000c;
    localparam logic [31:0] IAR_OFS_IBRL = 32'h00000010;
    localparam logic [31:0] IAR_OFS_IBRH = 32'h00000014;
    localparam int IAR_CTRL_DIAG = 0;
    localparam int IAR_CTRL_SEVEN = 1;
    localparam int IAR_CTRL_THREE = 2;
    localparam int IAR_STAT_MODE = 0;
    localparam int IAR_STAT_ODD = 1;
    localparam int IAR_STAT_CANCEL = 2;

    typedef enum logic [1:0] {
        IAR_IBR_HOLD,
        IAR_IBR_BUS,
        IAR_IBR_ACC,
        IAR_IBR_XAD
    } iar_ibr_src_t;

    typedef struct packed {
        logic [35:0] even_word;
        logic [35:0] odd_word;
        logic even_valid;
        logic odd_valid;
    } iar_bus_t;

    typedef struct packed {
        iar_ibr_src_t ibr_src;
        logic tag_from_bus;
        logic tag_from_ibr;
        logic tag_from_sr;
        logic ar_load;
        logic pc_load;
        logic [6:0] xr_load;
        logic trap_force;
        logic op_from_ibr;
        logic op_short;
        logic use_pc_addr;
        logic store_check;
    } iar_ctrl_t;
endpackage

// ---- iar_mem_model.sv ----
// even and odd core storage read-out model feeding the storage buses
// assumes the bench raises read_i for the cycles a word is on the buses
`timescale 1ns/1ps
module iar_mem_model
    import iar_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic read_i,
    input wire logic [35:0] even_i,
    input wire logic [35:0] odd_i,
    output iar_bus_t bus_o
);
    logic [35:0] even_last_r;
    logic [35:0] odd_last_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            even_last_r <= '0;
            odd_last_r <= '0;
        end else if (read_i) begin
            even_last_r <= even_i;
            odd_last_r <= odd_i;
        end
    end

    // both cores read out together; idle buses show inverted data so stale words are never mistaken
    assign bus_o.even_word = read_i ? even_i : ~even_last_r;
    assign bus_o.odd_word = read_i ? odd_i : ~odd_last_r;
    assign bus_o.even_valid = read_i;
    assign bus_o.odd_valid = read_i;
endmodule

// ---- testbench.sv ----
// self-checking bench for the instruction address register group
// assumes iar_pkg, iar_regs and iar_mem_model are compiled first
`timescale 1ns/1ps
module testbench;
    import iar_pkg::*;
    localparam logic [35:0] W_EV = 36'h9a5c3e1f7;
    localparam logic [35:0] W_OD = 36'h16b2d4c08;
    logic clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, rd_en, rerr;
    logic seven_i, three_i, mem_odd_o, cancel_o;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic [35:0] ev, od, acc, sw, ibr_o, gate_o;
    logic [14:0] index_adder_out, st_addr, a_o, b_o, xr_o, mas_o;
    logic [9:0] opc_o;
    logic [2:0] tag_o;
    logic [6:0] sel_o;
    iar_bus_t bus;
    iar_ctrl_t ctrl, c;
    int failures, n_compared, cycles;

    iar_mem_model i_iar_mem_model(.clk_i(clk_i), .arst_n_i(arst_n_i), .read_i(rd_en), .even_i(ev), .odd_i(od),
        .bus_o(bus));
    iar_regs i_iar_regs(.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_i(bus),
        .ctrl_i(ctrl), .index_adder_out_i(index_adder_out), .accumulator_reg_i(acc), .storage_word_reg_i(sw),
        .store_addr_i(st_addr), .enter_seven_index_mode_i(seven_i), .enter_three_index_mode_i(three_i),
        .instruction_backup_o(ibr_o), .storage_gate_o(gate_o), .operation_code_reg_o(opc_o),
        .index_tag_reg_o(tag_o), .index_select_o(sel_o), .adder_a_o(a_o), .adder_b_o(b_o), .adder_xr_o(xr_o),
        .memory_address_switch_o(mas_o), .mem_odd_o(mem_odd_o), .overlap_cancel_o(cancel_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [35:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk({4'h0, rdat}, exp);
        chk({35'h0, rerr}, 36'h0);
    endtask

    // control word held three edges so registered outputs have settled
    task automatic drive(input iar_ctrl_t cc, input logic [14:0] a);
        @(posedge clk_i);
        ctrl <= cc;
        index_adder_out <= a;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic t_reset();
        rd(IAR_OFS_STAT, 36'h0);
        rd(IAR_OFS_PC, 36'h0);
        rd(IAR_OFS_AR, 36'h0);
        apb(1'b0, 32'h00000018, 32'h00000000);
        chk({35'h0, rerr}, 36'h1);
    endtask

    task automatic t_bus(input logic odd);
        logic [35:0] e;
        logic [35:0] s;
        e = odd ? W_OD : W_EV;
        s = odd ? W_EV : W_OD;
        @(posedge clk_i);
        c = '0;
        c.ibr_src = IAR_IBR_BUS;
        c.tag_from_bus = 1'b1;
        ctrl <= c;
        rd_en <= 1'b1;
        ev <= W_EV;
        od <= W_OD;
        #1;
        chk(ibr_o, e);
        chk(gate_o, s);
        @(posedge clk_i);
        ctrl <= '0;
        rd_en <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk(ibr_o, e);
        chk(a_o, e[14:0]);
        chk(b_o, e[32:18]);
        chk(tag_o, s[17:15]);
        rd(IAR_OFS_IBRL, {4'h0, e[31:0]});
        rd(IAR_OFS_IBRH, {32'h0, e[35:32]});
    endtask

    task automatic t_acc();
        @(posedge clk_i);
        acc <= 36'h81234abcd;
        c = '0;
        c.ibr_src = IAR_IBR_ACC;
        ctrl <= c;
        #1;
        chk(ibr_o, W_EV);
        @(posedge clk_i);
        ctrl <= '0;
        #1;
        chk(ibr_o, acc);
        c = '0;
        c.op_from_ibr = 1'b1;
        drive(c, 15'h0000);
        chk(opc_o, {acc[35], acc[32:24]});
        c.op_short = 1'b1;
        drive(c, 15'h0000);
        chk({opc_o[9], opc_o[1:0]}, {acc[35], acc[34:33]});
        c = '0;
        c.ibr_src = IAR_IBR_XAD;
        drive(c, 15'h2b6d);
        chk(ibr_o, {acc[35:15], 15'h2b6d});
    endtask

    task automatic t_addr();
        c = '0;
        c.ar_load = 1'b1;
        drive(c, 15'h0001);
        rd(IAR_OFS_AR, 36'h1);
        chk(mas_o, 15'h0001);
        chk(mem_odd_o, 1'b1);
        apb(1'b1, IAR_OFS_CTRL, 32'h00000001);
        drive(c, 15'h0001);
        chk(mas_o[14], 1'b1);
        chk(mem_odd_o, 1'b0);
        apb(1'b1, IAR_OFS_CTRL, 32'h00000000);
        c = '0;
        c.trap_force = 1'b1;
        drive(c, 15'h0000);
        rd(IAR_OFS_AR, IAR_TRAP_FORCE | 15'h0001);
        rd(IAR_OFS_PC, IAR_TRAP_FORCE);
    endtask

    task automatic t_counter();
        c = '0;
        c.pc_load = 1'b1;
        c.use_pc_addr = 1'b1;
        drive(c, 15'h0005);
        rd(IAR_OFS_PC, 36'h5);
        chk(mas_o, 15'h0005);
        chk(mem_odd_o, 1'b1);
        t_bus(1'b1);
        @(posedge clk_i);
        st_addr <= 15'h0006;
        c = '0;
        c.store_check = 1'b1;
        drive(c, 15'h0000);
        chk(cancel_o, 1'b0);
        @(posedge clk_i);
        st_addr <= 15'h0005;
        drive(c, 15'h0000);
        chk(cancel_o, 1'b1);
    endtask

    task automatic t_index();
        c = '0;
        c.xr_load = 7'b0000001;
        drive(c, 15'h0f00);
        c.xr_load = 7'b0001000;
        drive(c, 15'h00f0);
        @(posedge clk_i);
        sw <= 36'h000028000;
        c = '0;
        c.tag_from_sr = 1'b1;
        drive(c, 15'h0000);
        chk(tag_o, 3'b101);
        chk(sel_o, 7'b0001001);
        chk(xr_o, 15'h0ff0);
        apb(1'b1, IAR_OFS_CTRL, 32'h00000002);
        // odd flag still set by the earlier trap, which forced address bit 17
        rd(IAR_OFS_STAT, 36'h3);
        chk(sel_o, 7'b0010000);
        chk(xr_o, 15'h0000);
        c = '0;
        c.tag_from_ibr = 1'b1;
        drive(c, 15'h0000);
        chk(tag_o, W_OD[17:15]);
        @(posedge clk_i);
        three_i <= 1'b1;
        @(posedge clk_i);
        three_i <= 1'b0;
        rd(IAR_OFS_STAT, 36'h2);
        @(posedge clk_i);
        seven_i <= 1'b1;
        @(posedge clk_i);
        seven_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd(IAR_OFS_STAT, 36'h3);
        apb(1'b1, IAR_OFS_CTRL, 32'h00000004);
        rd(IAR_OFS_STAT, 36'h2);
    endtask

    initial begin
        {psel, penable, pwrite, rd_en, seven_i, three_i} = '0;
        {paddr, pwdata, index_adder_out, st_addr} = '0;
        {ev, od, acc, sw, ctrl} = '0;
        arst_n_i = 1'b0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_bus(1'b0);
        t_acc();
        t_addr();
        t_counter();
        t_index();
        print_verdict();
    end
endmodule
